// >>> logic/vext_regs.sv
`timescale 1ns/10ps
// Vertical timing extension registers behind the indexed data port.
// Assumes writes to the index port are decoded outside and given as idx_wr.
module vext_regs
  import vext_pkg::*;
(
  input wire logic mclk,                 // Clock
  input wire logic rst_b,                // Async reset
  input wire logic idx_wr,               // Index port write strobe
  input wire logic data_wr,              // Data port write strobe
  input wire logic data_rd,              // Data port read strobe
  input wire logic [15:0] io_addr,       // Data port address
  input wire logic [7:0] io_wdata,       // Write data
  input wire logic std_lc8_wr,           // Standard overflow write of bit 4
  input wire logic std_lc8_val,          // Value written there
  input wire logic [15:0] start_low,     // Standard start address low 16
  input wire logic char_tick,            // Character clock pulse
  input wire logic interlace,            // Interlaced output
  input wire logic odd_field,            // Odd field
  input wire logic retrace_req,          // Undelayed retrace pulse
  output logic [7:0] io_rdata,           // Read data
  output logic [10:0] vert_total,        // Vertical total
  output logic [10:0] vert_disp_end,     // Display-enable end
  output logic [10:0] vert_retrace_start, // Retrace start
  output logic [10:0] vert_blank_start,  // Blanking start
  output logic line_compare_8,           // Line compare bit 8
  output logic [19:0] display_start,     // Display start address
  output logic retrace_go                // Skewed retrace pulse
);
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] ovf_low;
    logic [7:0] ovf_high;
    logic [7:0] skew;
    logic [7:0] start_up;
    logic [7:0] rdata;
    logic [10:0] vt;
    logic [10:0] vde;
    logic [10:0] vrs;
    logic [10:0] vbs;
    logic [19:0] dsa;
  } regs_t;
  regs_t r, next_r;
  logic port_hit;

  // ----------------------------------------
  // Register read decode
  // ----------------------------------------
  function automatic logic [7:0] read_reg(input regs_t q);
    case (q.index)
      IDX_OVF_LOW: read_reg = q.ovf_low;
      IDX_OVF_HIGH: read_reg = q.ovf_high & MASK_OVF_HIGH;
      IDX_SKEW: read_reg = q.skew;
      IDX_START_UP: read_reg = q.start_up & MASK_START_UP;
      default: read_reg = RESET_VAL;
    endcase
  endfunction

  assign port_hit = (io_addr == DATA_PORT);

  always_comb begin
    next_r = r;
    if (idx_wr) begin
      next_r.index = io_wdata;
    end
    if (data_wr && port_hit) begin
      case (r.index)
        IDX_OVF_LOW: next_r.ovf_low = io_wdata;
        IDX_OVF_HIGH: next_r.ovf_high = io_wdata & MASK_OVF_HIGH;
        IDX_SKEW: next_r.skew = io_wdata;
        IDX_START_UP: next_r.start_up = io_wdata & MASK_START_UP;
        default: ;
      endcase
    end
    // Shared bit; a standard-register write landing last wins the cycle
    if (std_lc8_wr) begin
      next_r.ovf_low[LC8_BIT] = std_lc8_val;
    end
    if (data_rd && port_hit) begin
      next_r.rdata = read_reg(r);
    end
    next_r.vt = {next_r.ovf_high[0], next_r.ovf_low[5], 9'h000};
    next_r.vt[8] = next_r.ovf_low[0];
    next_r.vde = {next_r.ovf_high[1], next_r.ovf_low[6], next_r.ovf_low[1], 8'h00};
    next_r.vrs = {next_r.ovf_high[4], next_r.ovf_low[7], next_r.ovf_low[2], 8'h00};
    next_r.vbs = {next_r.ovf_high[3], next_r.ovf_high[2], next_r.ovf_low[3], 8'h00};
    next_r.dsa = {next_r.start_up[3:0], start_low};
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Low eight bits of each vertical field live in other registers; only extension bits here
  assign io_rdata = r.rdata;
  assign vert_total = r.vt;
  assign vert_disp_end = r.vde;
  assign vert_retrace_start = r.vrs;
  assign vert_blank_start = r.vbs;
  assign line_compare_8 = r.ovf_low[LC8_BIT];
  assign display_start = r.dsa;

  vext_skew u_skew (
    .mclk(mclk),
    .rst_b(rst_b),
    .char_tick(char_tick),
    .interlace(interlace),
    .odd_field(odd_field),
    .retrace_req(retrace_req),
    .skew(r.skew),
    .retrace_go(retrace_go)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_VT_BITS: assert property (@(posedge mclk) disable iff (!rst_b)
    vert_total[10:8] == {r.ovf_high[0], r.ovf_low[5], r.ovf_low[0]})
    else $error("vertical total bits wrong");
  AST_VDE_BITS: assert property (@(posedge mclk) disable iff (!rst_b)
    vert_disp_end[10:8] == {r.ovf_high[1], r.ovf_low[6], r.ovf_low[1]})
    else $error("display end bits wrong");
  AST_VRS_BITS: assert property (@(posedge mclk) disable iff (!rst_b)
    vert_retrace_start[10:8] == {r.ovf_high[4], r.ovf_low[7], r.ovf_low[2]})
    else $error("retrace start bits wrong");
  AST_VBS_BITS: assert property (@(posedge mclk) disable iff (!rst_b)
    vert_blank_start[10:8] == {r.ovf_high[3:2], r.ovf_low[3]})
    else $error("blank start bits wrong");
  AST_LC8_SHARED: assert property (@(posedge mclk) disable iff (!rst_b)
    std_lc8_wr |=> line_compare_8 == $past(std_lc8_val))
    else $error("line compare bit not shared");
  AST_DSA_HIGH: assert property (@(posedge mclk) disable iff (!rst_b)
    display_start[19:16] == r.start_up[3:0] && r.start_up[7:4] == 4'h0)
    else $error("start address high bits wrong");
  AST_WRITE_TAKES: assert property (@(posedge mclk) disable iff (!rst_b)
    (data_wr && port_hit && r.index == IDX_SKEW) |=> r.skew == $past(io_wdata))
    else $error("skew write lost");
  AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (!rst_b)
    r.ovf_high[7:5] == 3'h0)
    else $error("reserved bits set");
  COV_WR_START: cover property (@(posedge mclk) disable iff (!rst_b)
    data_wr && port_hit && r.index == IDX_START_UP);
  COV_RD: cover property (@(posedge mclk) disable iff (!rst_b) data_rd && port_hit);
  COV_LC8: cover property (@(posedge mclk) disable iff (!rst_b) std_lc8_wr);
endmodule

// >>> logic/vext_pkg.sv
// Constants for the vertical timing extension register set.
// Assumes an 8-bit indexed port pair (index then data at 3CF) on one clock.
// Notes on behaviour
// - Vertical total is 11 bits: 8 from low ovf bit 0, 9 from bit 5, 10 from high ovf bit 0.
// - Display end is 11 bits: 8 from low ovf bit 1, 9 from bit 6, 10 from high ovf bit 1.
// - Retrace start is 11 bits: 8 from low ovf bit 2, 9 from bit 7, 10 from high ovf bit 4.
// - Blank start is 11 bits: 8 from low ovf bit 3, 9 and 10 from high ovf bits 2 and 3.
// - Line-compare bit 8 at low ovf bit 4 is one bit shared with the standard overflow reg.
// - In interlaced output the odd-field retrace is delayed by the programmed 0 to 255 character clocks.
// - Display start address is 20 bits, the top four from the start extension register.
// - Each register is reached by writing its index and then accessing the data port at 3CF.
package vext_pkg;
  localparam logic [15:0] DATA_PORT = 16'h03cf;
  localparam logic [7:0] IDX_OVF_LOW = 8'h78;
  localparam logic [7:0] IDX_OVF_HIGH = 8'h79;
  localparam logic [7:0] IDX_SKEW = 8'h7a;
  localparam logic [7:0] IDX_START_UP = 8'h7c;
  localparam logic [7:0] MASK_OVF_HIGH = 8'h1f;
  localparam logic [7:0] MASK_START_UP = 8'h0f;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam int LC8_BIT = 4;
endpackage

// >>> logic/vext_skew.sv
`timescale 1ns/10ps
// Odd-field retrace skew delay.
// Assumes char_tick pulses once per character clock.
module vext_skew
  import vext_pkg::*;
(
  input wire logic mclk,        // Clock
  input wire logic rst_b,       // Async reset
  input wire logic char_tick,   // Character clock pulse
  input wire logic interlace,   // Interlaced output
  input wire logic odd_field,   // Current field is odd
  input wire logic retrace_req, // Undelayed retrace start pulse
  input wire logic [7:0] skew,  // Programmed skew count
  output logic retrace_go       // Delayed retrace start pulse
);
  typedef enum logic [1:0] {IDLE = 2'b00, WAIT = 2'b01} skew_state_t;
  typedef struct packed {
    skew_state_t st;
    logic [7:0] cnt;
    logic go;
  } skew_t;
  skew_t s, next_s;

  always_comb begin
    next_s = s;
    next_s.go = 1'b0;
    case (s.st)
      IDLE: begin
        if (retrace_req) begin
          if (interlace && odd_field && skew != 8'h00) begin
            next_s.st = WAIT;
            next_s.cnt = skew;
          end else begin
            next_s.go = 1'b1;
          end
        end
      end
      WAIT: begin
        if (char_tick) begin
          if (s.cnt == 8'h01) begin
            next_s.st = IDLE;
            next_s.go = 1'b1;
          end
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      default: next_s.st = IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign retrace_go = s.go;

  AST_EVEN_NO_DELAY: assert property (@(posedge mclk) disable iff (!rst_b)
    (s.st == IDLE && retrace_req && !(interlace && odd_field)) |=> retrace_go)
    else $error("even field retrace delayed");
  AST_WAIT_NO_GO: assert property (@(posedge mclk) disable iff (!rst_b)
    (s.st == WAIT && s.cnt > 8'h01) |=> !retrace_go)
    else $error("retrace before skew elapsed");
  COV_SKEWED: cover property (@(posedge mclk) disable iff (!rst_b)
    s.st == WAIT ##[1:300] retrace_go);
endmodule

// >>> tb/vext_regs_tb_top.sv
// Self-checking bench for the vertical timing extension registers.
// Assumes the indexed port contract: index write, then data access at 3CF.
`timescale 1ns/10ps
module vext_regs_tb_top;
  import vext_pkg::*;
  logic mclk = 0, rst_b = 0, idx_wr = 0, data_wr = 0, data_rd = 0;
  logic std_lc8_wr = 0, std_lc8_val = 0, char_tick = 0, interlace = 0;
  logic odd_field = 0, retrace_req = 0, line_compare_8, retrace_go;
  logic [15:0] io_addr = DATA_PORT, start_low = 16'hbeef;
  logic [7:0] io_wdata = 8'h00, io_rdata, a, b;
  logic [10:0] vert_total, vert_disp_end, vert_retrace_start, vert_blank_start;
  logic [19:0] display_start;
  int failures = 0, n_checks = 0, ticks, gos, at;
  logic [7:0] pa [3] = '{8'h55, 8'haa, 8'hff};
  logic [7:0] pb [3] = '{8'h0a, 8'h15, 8'hff};
  logic [7:0] sk [4] = '{8'h03, 8'h03, 8'h03, 8'h00};
  logic [2:0] mode [4] = '{3'b110, 3'b100, 3'b010, 3'b110};
  int exp_t [4] = '{3, 0, 0, 0};

  vext_regs u_vext_regs (.mclk(mclk), .rst_b(rst_b), .idx_wr(idx_wr), .data_wr(data_wr),
    .data_rd(data_rd), .io_addr(io_addr), .io_wdata(io_wdata), .std_lc8_wr(std_lc8_wr),
    .std_lc8_val(std_lc8_val), .start_low(start_low), .char_tick(char_tick),
    .interlace(interlace), .odd_field(odd_field), .retrace_req(retrace_req),
    .io_rdata(io_rdata), .vert_total(vert_total), .vert_disp_end(vert_disp_end),
    .vert_retrace_start(vert_retrace_start), .vert_blank_start(vert_blank_start),
    .line_compare_8(line_compare_8), .display_start(display_start),
    .retrace_go(retrace_go));

  always #5 mclk = ~mclk;

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic put(input logic iw, dw, dr, input logic [15:0] ad, input logic [7:0] d);
    @(negedge mclk);
    idx_wr = iw;
    data_wr = dw;
    data_rd = dr;
    io_addr = ad;
    io_wdata = d;
  endtask

  task automatic wr_reg(input logic [7:0] idx, d, input logic [15:0] ad = DATA_PORT);
    put(1'b1, 1'b0, 1'b0, DATA_PORT, idx);
    put(1'b0, 1'b1, 1'b0, ad, d);
    put(1'b0, 1'b0, 1'b0, DATA_PORT, d);
  endtask

  task automatic rd_check(input string name, input logic [7:0] idx, exp);
    put(1'b1, 1'b0, 1'b0, DATA_PORT, idx);
    put(1'b0, 1'b0, 1'b1, DATA_PORT, 8'h00);
    put(1'b0, 1'b0, 1'b0, DATA_PORT, 8'h00);
    check(name, {12'h000, io_rdata}, {12'h000, exp});
  endtask

  task automatic lc8_pulse(input logic v);
    @(negedge mclk);
    std_lc8_wr = 1'b1;
    std_lc8_val = v;
    @(negedge mclk);
    std_lc8_wr = 1'b0;
    @(negedge mclk);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    rd_check("ovf low", IDX_OVF_LOW, 8'h00);
    rd_check("ovf high", IDX_OVF_HIGH, 8'h00);
    rd_check("skew", IDX_SKEW, 8'h00);
    rd_check("start up", IDX_START_UP, 8'h00);
    check("start rst", display_start, {4'h0, start_low});
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      a = pa[k];
      b = pb[k];
      wr_reg(IDX_OVF_LOW, a);
      wr_reg(IDX_OVF_HIGH, b);
      check("total", 20'(vert_total), 20'({b[0], a[5], a[0], 8'h00}));
      check("disp end", 20'(vert_disp_end), 20'({b[1], a[6], a[1], 8'h00}));
      check("retrace", 20'(vert_retrace_start), 20'({b[4], a[7], a[2], 8'h00}));
      check("blank", 20'(vert_blank_start), 20'({b[3], b[2], a[3], 8'h00}));
      check("lc8", 20'(line_compare_8), 20'(a[4]));
      rd_check("ovf low rd", IDX_OVF_LOW, a);
      rd_check("ovf high rd", IDX_OVF_HIGH, b & 8'h1f);
    end
    foreach (pa[k]) begin
      wr_reg(IDX_START_UP, pa[k]);
      check("start", display_start, {pa[k][3:0], start_low});
      rd_check("start rd", IDX_START_UP, pa[k] & 8'h0f);
    end
    $display("test fields done");
    wr_reg(IDX_OVF_LOW, 8'h00);
    lc8_pulse(1'b1);
    check("lc8 std", 20'(line_compare_8), 20'h00001);
    rd_check("lc8 rd", IDX_OVF_LOW, 8'h10);
    lc8_pulse(1'b0);
    rd_check("lc8 clr", IDX_OVF_LOW, 8'h00);
    wr_reg(IDX_SKEW, 8'h5a);
    wr_reg(IDX_SKEW, 8'hff, 16'h03ce);
    rd_check("wrong port", IDX_SKEW, 8'h5a);
    rd_check("unmapped", 8'h7b, 8'h00);
    $display("test port done");
    for (int k = 0; k < 4; k++) begin
      wr_reg(IDX_SKEW, sk[k]);
      interlace = mode[k][2];
      odd_field = mode[k][1];
      @(negedge mclk);
      retrace_req = 1'b1;
      ticks = 0;
      gos = 0;
      at = 99;
      for (int i = 1; i <= 20; i++) begin
        @(negedge mclk);
        retrace_req = 1'b0;
        if (retrace_go === 1'b1) begin
          gos++;
          if (gos == 1)
            at = ticks;
        end
        char_tick = (i % 2 == 0);
        if (char_tick)
          ticks++;
      end
      char_tick = 1'b0;
      check("skew ticks", 20'(at), 20'(exp_t[k]));
      check("skew pulses", 20'(gos), 20'h00001);
    end
    $display("test skew done");
    complete_run();
  end

  // Tests need about 200 cycles; generous margin
  initial begin
    #50us;
    failures++;
    complete_run();
  end
endmodule
